// ---- timer_two_control_unit_tb_top.sv ----
`timescale 1ns/1ps
module timer_two_control_unit_tb_top;
   import ttc_pkg::*;
   logic clk, rst, read, write, waitrequest, ecnt, trig, t1_ovf, rx_tick, tx_tick, irq;
   logic [7:0] address;
   logic [31:0] writedata, readdata, v;
   int err_total, n_tests, n_rx, n_tx, r0, t0;
   ttc_timer_two dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .external_count_input(ecnt), .trigger_input(trig), .timer1_overflow(t1_ovf),
      .rx_clock_tick(rx_tick), .tx_clock_tick(tx_tick), .irq(irq));
   ttc_pin_model pins (.clk(clk), .rst(rst), .count_pin(ecnt), .trigger_pin(trig),
      .t1_ovf(t1_ovf));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // serial clock pulses seen per window
   always @(posedge clk) begin
      if (rx_tick === 1'b1) n_rx <= n_rx + 1;
      if (tx_tick === 1'b1) n_tx <= n_tx + 1;
   end
   task automatic report_and_stop();
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic ok, input string what);
      n_tests++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : chk
   // wait for the slave's answer; the watchdog cuts a hang short
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      v = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      chk(v === exp, what);
   endtask : rd_chk
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      report_and_stop();
   end
   initial begin
      {read, write, address, writedata, err_total, n_tests} = '0;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk(irq === 1'b0 && rx_tick === 1'b0, "outputs in reset");
      rd_chk(TTC_CTRL_OFS, 32'h0, "control reset value");
      rd_chk(8'h40, 32'h0, "unmapped read");
      // timer overflow sets the sticky flag and reloads
      bus(1, TTC_RELOAD_OFS, 32'hFFF0);
      bus(1, TTC_COUNT_OFS, 32'hFFFE);
      bus(1, TTC_CTRL_OFS, 32'h04);
      repeat (40) @(posedge clk);
      rd_chk(TTC_CTRL_OFS, 32'h84, "overflow flag");
      bus(1, TTC_CTRL_OFS, 32'h80);
      bus(0, TTC_COUNT_OFS, 32'h0);
      chk(v >= 32'hFFF0 && v <= 32'hFFF3, "count after reload");
      repeat (50) @(posedge clk);
      rd_chk(TTC_COUNT_OFS, v, "count holds when stopped");
      rd_chk(TTC_IRQ_STAT_OFS, 32'h1, "overflow status");
      chk(irq === 1'b0, "irq masked");
      bus(1, TTC_IRQ_MASK_OFS, 32'h3);
      repeat (2) @(posedge clk);
      chk(irq === 1'b1, "irq raised");
      bus(1, TTC_IRQ_STAT_OFS, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq === 1'b0, "irq cleared");
      rd_chk(TTC_CTRL_OFS, 32'h80, "flag stays set");
      bus(1, TTC_CTRL_OFS, 32'h00);
      rd_chk(TTC_CTRL_OFS, 32'h00, "software clear");
      // event counting on the external pin
      bus(1, TTC_COUNT_OFS, 32'h0);
      bus(1, TTC_CTRL_OFS, 32'h06);
      repeat (3) pins.fall_edge(1'b0);
      repeat (30) @(posedge clk);
      rd_chk(TTC_COUNT_OFS, 32'h3, "external count");
      // trigger ignored when external enable is clear
      bus(1, TTC_CTRL_OFS, 32'h03);
      pins.fall_edge(1'b1);
      repeat (4) @(posedge clk);
      rd_chk(TTC_CTRL_OFS, 32'h03, "trigger ignored");
      rd_chk(TTC_RELOAD_OFS, 32'hFFF0, "no capture");
      // capture copies the counter and leaves it alone
      bus(1, TTC_COUNT_OFS, 32'h1234);
      bus(1, TTC_CTRL_OFS, 32'h0B);
      pins.fall_edge(1'b1);
      repeat (4) @(posedge clk);
      rd_chk(TTC_CTRL_OFS, 32'h4B, "external flag on capture");
      rd_chk(TTC_RELOAD_OFS, 32'h1234, "captured value");
      rd_chk(TTC_COUNT_OFS, 32'h1234, "counter unchanged");
      chk(irq === 1'b1, "external flag interrupt");
      bus(1, TTC_IRQ_STAT_OFS, 32'h3);
      // trigger reload while running
      bus(1, TTC_RELOAD_OFS, 32'h5555);
      bus(1, TTC_CTRL_OFS, 32'h0E);
      pins.fall_edge(1'b1);
      repeat (4) @(posedge clk);
      rd_chk(TTC_COUNT_OFS, 32'h5555, "trigger reload");
      // with selects clear the serial port follows timer one
      bus(1, TTC_CTRL_OFS, 32'h00);
      r0 = n_rx;
      t0 = n_tx;
      repeat (400) @(posedge clk);
      r0 = n_rx - r0;
      t0 = n_tx - t0;
      chk(r0 >= 9 && r0 <= 11 && t0 == r0, "timer one ticks");
      // serial clock mode: every 4 ticks of 2 clocks, no overflow flag
      bus(1, TTC_RELOAD_OFS, 32'hFFFC);
      bus(1, TTC_COUNT_OFS, 32'hFFFC);
      bus(1, TTC_CTRL_OFS, 32'h3D);
      r0 = n_rx;
      t0 = n_tx;
      repeat (400) @(posedge clk);
      r0 = n_rx - r0;
      t0 = n_tx - t0;
      chk(r0 >= 48 && r0 <= 51 && t0 == r0, "own overflow ticks");
      pins.fall_edge(1'b1);
      repeat (4) @(posedge clk);
      rd_chk(TTC_CTRL_OFS, 32'h7D, "serial mode flags");
      bus(1, TTC_CTRL_OFS, 32'h2C);
      r0 = n_rx;
      t0 = n_tx;
      repeat (200) @(posedge clk);
      r0 = n_rx - r0;
      t0 = n_tx - t0;
      chk(r0 >= 24 && t0 >= 4 && t0 <= 6, "split selects");
      // up/down mode: a trigger edge raises no external event and no interrupt
      bus(1, TTC_CTRL_OFS, 32'h08);
      bus(1, TTC_IRQ_STAT_OFS, 32'h3);
      bus(1, 8'hCC, 32'h1);
      pins.fall_edge(1'b1);
      rd_chk(TTC_IRQ_STAT_OFS, 32'h0, "no external event");
      chk(irq === 1'b0, "no interrupt in up/down mode");
      // counting down: underflow at the reload value loads all ones and toggles the flag
      bus(1, TTC_RELOAD_OFS, 32'h0100);
      bus(1, TTC_COUNT_OFS, 32'h0101);
      pins.trigger_pin <= 1'b0;
      bus(1, TTC_CTRL_OFS, 32'h0C);
      repeat (30) @(posedge clk);
      rd_chk(TTC_CTRL_OFS, 32'hCC, "underflow flags");
      bus(0, TTC_COUNT_OFS, 32'h0);
      chk(v >= 32'hFFFD && v <= 32'hFFFF, "underflow load");
      rd_chk(TTC_IRQ_STAT_OFS, 32'h1, "toggle raises no external event");
      report_and_stop();
   end
endmodule : timer_two_control_unit_tb_top

// ---- ttc_fall_detect.sv ----
`timescale 1ns/1ps
module ttc_fall_detect
   import ttc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic level,
   output logic fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic fall_q;

   // two flops before any logic looks at the pin
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 1'h1;
         sync_q <= 1'h1;
         prev_q <= 1'h1;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // one pulse per high to low change
   always_ff @(posedge clk) begin
      if (rst) begin
         fall_q <= 1'h0;
      end else begin
         fall_q <= prev_q & ~sync_q;
      end
   end

   assign level = sync_q;
   assign fall = fall_q;

   property p_one_event;
      @(posedge clk) disable iff (rst) fall_q |-> !prev_q && $past(sync_q, 2);
   endproperty
   a_one_event: assert property (p_one_event) else $error("fall pulse without a falling input");

endmodule : ttc_fall_detect

// ---- ttc_pin_model.sv ----
`timescale 1ns/1ps
module ttc_pin_model
   import ttc_pkg::*;
#(
   parameter int T1_PERIOD = 40
)
(
   input wire logic clk,
   input wire logic rst,
   output logic count_pin,
   output logic trigger_pin,
   output logic t1_ovf
);
   int t1_cnt;
   // pins idle high like pulled-up port lines
   initial begin
      count_pin = 1'b1;
      trigger_pin = 1'b1;
   end
   // timer one overflow source: a one-cycle pulse at a fixed rate
   always @(posedge clk) begin
      if (rst) begin
         t1_cnt <= 0;
         t1_ovf <= 1'b0;
      end else begin
         t1_cnt <= (t1_cnt == T1_PERIOD - 1) ? 0 : t1_cnt + 1;
         t1_ovf <= (t1_cnt == T1_PERIOD - 1);
      end
   end
   // each level lasts 4 clocks, so the two-flop synchroniser always sees it
   task automatic fall_edge(input bit trig);
      @(posedge clk);
      trigger_pin <= trigger_pin & !trig;
      count_pin <= count_pin & trig;
      repeat (4) @(posedge clk);
      if (trig) trigger_pin <= 1'b1;
      else count_pin <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : fall_edge
endmodule : ttc_pin_model

// ---- ttc_pkg.sv ----
// Behaviour
// - Overflow flag, control bit 7, set on counter overflow; only software clears it.
// - Overflow flag is never set while either serial clock select bit is one.
// - External flag, bit 6, set by an enabled trigger falling edge; software clears it.
// - Set external flag requests the timer interrupt, except while the mode register's direction enable bit is one.
// - Receive clock select, bit 5: receiver ticks on our overflows, else timer one.
// - Transmit clock select, bit 4: transmitter ticks on our overflows, else timer one.
// - External enable, bit 3, lets trigger edges capture or reload; clear ignores them.
// - Counter runs only while run control, bit 2, is one; otherwise holds.
// - Counter select, bit 1: zero counts internal ticks, one counts external falling edges.
// - Capture select one with external enable: each trigger falling edge captures.
// - Capture select zero: reload on overflow, and on trigger edges when enabled; here trigger edges reload only while run control is one.
// - Serial clock mode ignores capture select and forces reload on every overflow.
// - Control register at 0C8H, resets to zero: stopped, flags clear, serial deselected.
// - Up counting reaches 0FFFFH, overflows and loads the reload pair; in capture mode it wraps to zero instead.
// - Timer ticks every twelve oscillator clocks, or every two in serial clock mode.
// - In serial clock mode an enabled trigger edge sets the flag without reload.
package ttc_pkg;

   // register byte addresses on the bus
   localparam logic [7:0] TTC_CTRL_OFS = 8'hC8;
   localparam logic [7:0] TTC_MODE_OFS = 8'hCC;
   localparam logic [7:0] TTC_RELOAD_OFS = 8'hD0;
   localparam logic [7:0] TTC_COUNT_OFS = 8'hD4;
   localparam logic [7:0] TTC_IRQ_STAT_OFS = 8'hD8;
   localparam logic [7:0] TTC_IRQ_MASK_OFS = 8'hDC;

   // values after reset, and the counter's top value
   localparam logic [7:0] TTC_CTRL_RST = 8'h00;
   localparam logic TTC_MODE_RST = 1'h0;
   localparam logic [15:0] TTC_RELOAD_RST = 16'h0000;
   localparam logic [15:0] TTC_COUNT_RST = 16'h0000;
   localparam logic [1:0] TTC_IRQ_RST = 2'h0;
   localparam logic [15:0] TTC_COUNT_MAX = 16'hFFFF;

   // field positions outside the control byte
   localparam int TTC_MODE_DIR_BIT = 0;
   localparam int TTC_IRQ_OVF_BIT = 0;
   localparam int TTC_IRQ_EXT_BIT = 1;

   // oscillator clocks per machine cycle and per state time
   localparam int TTC_MACHINE_DIV = 12;
   localparam int TTC_STATE_DIV = 2;

   // control byte, bit 7 first
   typedef struct packed {
      logic overflow_flag;
      logic external_flag;
      logic receive_clock_select;
      logic transmit_clock_select;
      logic external_enable;
      logic run_control;
      logic counter_select;
      logic capture_reload_select;
   } ttc_ctrl_t;

endpackage : ttc_pkg

// ---- ttc_prescaler.sv ----
`timescale 1ns/1ps
module ttc_prescaler
   import ttc_pkg::*;
#(
   parameter int DIV = TTC_MACHINE_DIV
)
(
   input wire logic clk,
   input wire logic rst,
   output logic tick
);
   localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_q;
   logic tick_q;

   // free running divider; one tick pulse every DIV clocks
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         tick_q <= 1'h0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
         tick_q <= 1'h1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick_q <= 1'h0;
      end
   end

   assign tick = tick_q;

endmodule : ttc_prescaler

// ---- ttc_timer_two.sv ----
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ttc_timer_two
   import ttc_pkg::*;
#(
   parameter int MACHINE_DIV = TTC_MACHINE_DIV,
   parameter int STATE_DIV = TTC_STATE_DIV
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic external_count_input,
   input wire logic trigger_input,
   input wire logic timer1_overflow,
   output logic rx_clock_tick,
   output logic tx_clock_tick,
   output logic irq
);
   ttc_ctrl_t ctrl_q;
   ttc_ctrl_t ctrl_d;
   logic dir_en_q;
   logic [15:0] reload_q;
   logic [15:0] count_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic irq_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic rx_q;
   logic tx_q;

   logic ext_fall;
   logic trig_fall;
   logic trig_level;
   logic tick_mc;
   logic tick_st;

   // input synchronisers and tick sources
   ttc_fall_detect u_count_pin (
      .clk(clk),
      .rst(rst),
      .pin(external_count_input),
      .level(),
      .fall(ext_fall)
   );

   ttc_fall_detect u_trig_pin (
      .clk(clk),
      .rst(rst),
      .pin(trigger_input),
      .level(trig_level),
      .fall(trig_fall)
   );

   ttc_prescaler #(.DIV(MACHINE_DIV)) u_machine_tick (
      .clk(clk),
      .rst(rst),
      .tick(tick_mc)
   );

   ttc_prescaler #(.DIV(STATE_DIV)) u_state_tick (
      .clk(clk),
      .rst(rst),
      .tick(tick_st)
   );

   // bus access strobes: a write lands at the edge where waitrequest is low
   logic wr_en;
   logic rd_take;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_reload;
   logic wr_count;
   logic wr_stat;
   logic wr_mask;
   assign wr_en = write & ~wait_q;
   assign rd_take = read & wait_q;
   assign wr_ctrl = wr_en && (address == TTC_CTRL_OFS);
   assign wr_mode = wr_en && (address == TTC_MODE_OFS);
   assign wr_reload = wr_en && (address == TTC_RELOAD_OFS);
   assign wr_count = wr_en && (address == TTC_COUNT_OFS);
   assign wr_stat = wr_en && (address == TTC_IRQ_STAT_OFS);
   assign wr_mask = wr_en && (address == TTC_IRQ_MASK_OFS);

   // operating mode decode
   logic baud;
   logic updown;
   logic dir_up;
   logic count_tick;
   assign baud = ctrl_q.receive_clock_select | ctrl_q.transmit_clock_select;
   // up/down only applies to plain auto-reload; serial mode forces reload
   assign updown = dir_en_q & ~baud & ~ctrl_q.capture_reload_select;
   assign dir_up = ~updown | trig_level;
   // tick source: external edges, state time in serial mode, else machine cycle
   assign count_tick = ctrl_q.run_control &
      (ctrl_q.counter_select ? ext_fall : (baud ? tick_st : tick_mc));

   // counter events
   logic ovf;
   logic unf;
   logic trig_evt;
   logic capture;
   logic reload_evt;
   logic set_ovf_flag;
   logic set_ext_flag;
   logic toggle_ext_flag;
   assign ovf = count_tick && dir_up && (count_q == TTC_COUNT_MAX);
   assign unf = count_tick && !dir_up && (count_q == reload_q);
   // in up/down mode the trigger pin is the direction, not an event source
   assign trig_evt = trig_fall & ctrl_q.external_enable & ~updown;
   assign capture = trig_evt & ctrl_q.capture_reload_select & ~baud;
   // a stopped counter is not reloaded by the pin, so it truly holds
   assign reload_evt = trig_evt & ~ctrl_q.capture_reload_select & ~baud
      & ctrl_q.run_control;
   assign set_ovf_flag = (ovf | unf) & ~baud;
   assign set_ext_flag = trig_evt;
   assign toggle_ext_flag = updown & (ovf | unf);

   // control register; hardware set wins over a software clear
   always_comb begin
      ctrl_d = wr_ctrl ? ttc_ctrl_t'(writedata[7:0]) : ctrl_q;
      if (set_ovf_flag) begin
         ctrl_d.overflow_flag = 1'h1;
      end
      if (toggle_ext_flag) begin
         ctrl_d.external_flag = ~ctrl_q.external_flag;
      end else if (set_ext_flag) begin
         ctrl_d.external_flag = 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= ttc_ctrl_t'(TTC_CTRL_RST);
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // mode register: direction enable
   always_ff @(posedge clk) begin
      if (rst) begin
         dir_en_q <= TTC_MODE_RST;
      end else if (wr_mode) begin
         dir_en_q <= writedata[TTC_MODE_DIR_BIT];
      end
   end

   // reload pair; capture copies the live count in
   always_ff @(posedge clk) begin
      if (rst) begin
         reload_q <= TTC_RELOAD_RST;
      end else if (wr_reload) begin
         reload_q <= writedata[15:0];
      end else if (capture) begin
         reload_q <= count_q;
      end
   end

   // counter; capture mode wraps through zero, other modes reload
   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= TTC_COUNT_RST;
      end else if (wr_count) begin
         count_q <= writedata[15:0];
      end else if (ovf && (!ctrl_q.capture_reload_select || baud)) begin
         count_q <= reload_q;
      end else if (unf) begin
         count_q <= TTC_COUNT_MAX;
      end else if (reload_evt) begin
         count_q <= reload_q;
      end else if (count_tick) begin
         count_q <= dir_up ? count_q + 16'h0001 : count_q - 16'h0001;
      end
   end

   // serial port clock selection, registered so the pulses are clean
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_q <= 1'h0;
         tx_q <= 1'h0;
      end else begin
         rx_q <= ctrl_q.receive_clock_select ? (ovf & baud) : timer1_overflow;
         tx_q <= ctrl_q.transmit_clock_select ? (ovf & baud) : timer1_overflow;
      end
   end

   // sticky interrupt status, write one to clear, set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat_q <= TTC_IRQ_RST;
         irq_mask_q <= TTC_IRQ_RST;
      end else begin
         irq_stat_q[TTC_IRQ_OVF_BIT] <= set_ovf_flag |
            (irq_stat_q[TTC_IRQ_OVF_BIT] & ~(wr_stat & writedata[TTC_IRQ_OVF_BIT]));
         // the toggling flag of up/down mode never reaches the interrupt
         irq_stat_q[TTC_IRQ_EXT_BIT] <= (set_ext_flag & ~dir_en_q) |
            (irq_stat_q[TTC_IRQ_EXT_BIT] & ~(wr_stat & writedata[TTC_IRQ_EXT_BIT]));
         if (wr_mask) begin
            irq_mask_q <= writedata[1:0];
         end
      end
   end

   // level interrupt while any unmasked status bit stands
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'h0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // one wait cycle per access; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_q <= 1'h1;
      end else if ((read | write) && wait_q) begin
         wait_q <= 1'h0;
      end else begin
         wait_q <= 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
      end else if (rd_take) begin
         case (address)
            TTC_CTRL_OFS: rdata_q <= {24'h000000, ctrl_q};
            TTC_MODE_OFS: rdata_q <= {31'h00000000, dir_en_q};
            TTC_RELOAD_OFS: rdata_q <= {16'h0000, reload_q};
            TTC_COUNT_OFS: rdata_q <= {16'h0000, count_q};
            TTC_IRQ_STAT_OFS: rdata_q <= {30'h00000000, irq_stat_q};
            TTC_IRQ_MASK_OFS: rdata_q <= {30'h00000000, irq_mask_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   assign readdata = rdata_q;
   assign waitrequest = wait_q;
   assign rx_clock_tick = rx_q;
   assign tx_clock_tick = tx_q;
   assign irq = irq_q;

   // checks
   property p_ovf_flag;
      @(posedge clk) disable iff (rst) ovf && !baud |=> ctrl_q.overflow_flag;
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

   property p_no_flag_baud;
      @(posedge clk) disable iff (rst)
         baud && !ctrl_q.overflow_flag && !wr_ctrl |=> !ctrl_q.overflow_flag;
   endproperty
   a_no_flag_baud: assert property (p_no_flag_baud) else $error("flag set in serial mode");

   property p_ext_flag;
      @(posedge clk) disable iff (rst)
         trig_fall && ctrl_q.external_enable && !dir_en_q |=> ctrl_q.external_flag;
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("trigger edge lost");

   property p_ext_irq;
      @(posedge clk) disable iff (rst)
         set_ext_flag && !dir_en_q && irq_mask_q[TTC_IRQ_EXT_BIT] |=> ##1 irq_q;
   endproperty
   a_ext_irq: assert property (p_ext_irq) else $error("external flag raised no interrupt");

   property p_rx_sel;
      @(posedge clk) disable iff (rst)
         1'b1 |=> rx_q == ($past(ctrl_q.receive_clock_select) ?
            $past(ovf) : $past(timer1_overflow));
   endproperty
   a_rx_sel: assert property (p_rx_sel) else $error("receive tick from nowhere");

   property p_tx_own;
      @(posedge clk) disable iff (rst)
         ctrl_q.transmit_clock_select && ovf |=> tx_q;
   endproperty
   a_tx_own: assert property (p_tx_own) else $error("transmit tick missing");

   property p_hold;
      @(posedge clk) disable iff (rst)
         !ctrl_q.run_control && !wr_count |=> $stable(count_q);
   endproperty
   a_hold: assert property (p_hold) else $error("stopped counter moved");

   property p_capture;
      @(posedge clk) disable iff (rst)
         capture && !wr_reload && !wr_count |=> reload_q == $past(count_q);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");

   property p_reload;
      @(posedge clk) disable iff (rst)
         ovf && (!ctrl_q.capture_reload_select || baud) && !wr_count
         |=> count_q == $past(reload_q);
   endproperty
   a_reload: assert property (p_reload) else $error("overflow did not reload");

   // cycles since the last machine tick; a counter keeps the rate check free of long repeats
   int mc_gap_q;
   logic mc_seen_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         mc_gap_q <= 0;
         mc_seen_q <= 1'h0;
      end else if (tick_mc) begin
         mc_gap_q <= 0;
         mc_seen_q <= 1'h1;
      end else begin
         mc_gap_q <= mc_gap_q + 1;
      end
   end

   // the first tick after reset has no predecessor, so checking starts after it
   property p_machine_rate;
      @(posedge clk) disable iff (rst)
         mc_seen_q |-> mc_gap_q < MACHINE_DIV && (!tick_mc || mc_gap_q == MACHINE_DIV - 1);
   endproperty
   a_machine_rate: assert property (p_machine_rate) else $error("machine tick rate off");

   property p_bus_answer;
      @(posedge clk) disable iff (rst) (read || write) && wait_q |=> !wait_q ##1 wait_q;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

   c_baud_ovf: cover property (@(posedge clk) disable iff (rst) ovf && baud);
   c_capture: cover property (@(posedge clk) disable iff (rst) capture);
   c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq_q));

endmodule : ttc_timer_two
